// File: core/ldmc_mode_ctrl.sv
// Overview of operation
// - Auto-increment flag reads 1; range bits writable
// - Sleep bit set stops the oscillator
// - Oscillator ready 500 us after wake
// - No modulation while oscillator stopped
// - Three secondary address enables, first on
// - Broadcast address enable resets to one
// - Thermal and summary error status bits
// - Group select: dimming or blinking
// - Fault clear strobe self-clears, clears error summary
// - Errors set again on new fault
// - Outputs update at stop or ack
// - Six selector registers, four channels each
// - Every selector resets to individual mode
// - Selector 00 turns channel off
// - Selector 01 fully on, gated by enable
// - Selector 10 uses individual brightness
// - Selector 11 uses brightness and group
// - Group dimming at fixed 122 Hz
// - Individual modulation 31.25 kHz, value/256 duty
module ldmc_mode_ctrl #(
  parameter int unsigned NUM_CH      = ldmc_pkg::NUM_CH,
  parameter int unsigned WAKE_CYCLES = 32'(ldmc_pkg::WAKE_CYCLES)
) (
  input  wire logic                       sys_clk,
  input  wire logic                       reset,
  input  wire logic                       bus_soft_reset,
  input  wire logic [ldmc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       bus_stop,
  output logic      [7:0]                 reg_rdata,
  input  wire logic                       output_enable_n,
  input  wire logic                       thermal_alarm,
  input  wire logic                       fault_detect,
  input  wire logic [NUM_CH*8-1:0]        channel_brightness_reg,
  input  wire logic [7:0]                 group_duty_reg,
  input  wire logic [7:0]                 group_period_reg,
  output logic                            autoinc_range_hi,
  output logic                            autoinc_range_lo,
  output logic                            secondary_addr_one_en,
  output logic                            secondary_addr_two_en,
  output logic                            secondary_addr_three_en,
  output logic                            broadcast_addr_en,
  output logic                            osc_enable,
  output logic                            osc_ready,
  output logic                            fault_clear_strobe,
  output logic [NUM_CH-1:0]               led_drive
);

  // Four 2-bit selectors to a register, lowest channel in the lowest bits
  localparam int unsigned SEL_W      = 2;
  localparam int unsigned CH_PER_SEL = 4;
  localparam logic [7:0]  CNT_LAST   = 8'hff;
  localparam int unsigned NUM_SEL    = NUM_CH / CH_PER_SEL;
  localparam int unsigned STEP_W  = $clog2(ldmc_pkg::STEP_CYCLES + 1);
  localparam int unsigned WAKE_W  = $clog2(WAKE_CYCLES + 1);
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(ldmc_pkg::STEP_CYCLES - 1);
  localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_CYCLES - 1);
  localparam logic [3:0]        BLINK_PRE_LAST = 4'(ldmc_pkg::BLINK_PRESCALE - 1);

  // Selector register index of an address, valid only inside the selector range
  function automatic logic [2:0] sel_index(input logic [ldmc_pkg::ADDR_W-1:0] addr);
    logic [ldmc_pkg::ADDR_W-1:0] diff;
    diff = addr - ldmc_pkg::CHANNEL_STATE_BASE_ADDR;
    return diff[2:0];
  endfunction

  function automatic logic is_sel_addr(input logic [ldmc_pkg::ADDR_W-1:0] addr);
    return (addr >= ldmc_pkg::CHANNEL_STATE_BASE_ADDR) && (addr <= ldmc_pkg::CHANNEL_STATE_LAST_ADDR);
  endfunction

  logic                 soft_rst;
  logic [7:0]           mode_one;
  logic                 group_blink_select;
  logic                 update_on_ack_select;
  logic                 thermal_fault_flag;
  logic                 error_summary;
  logic [7:0]           sel_shadow [NUM_SEL];
  logic [7:0]           sel_active [NUM_SEL];
  logic                 oe_meta, oe_sync_n;
  logic                 therm_meta, therm_sync;
  logic [STEP_W-1:0]    step_div;
  logic                 step_tick;
  logic [7:0]           indiv_cnt;
  logic                 period_tick;
  logic [7:0]           group_cnt;
  logic [3:0]           blink_pre;
  logic [7:0]           blink_div;
  logic                 group_step;
  logic [WAKE_W-1:0]    wake_cnt;
  logic                 wr_mode_one, wr_mode_two, wr_sel;

  // Both resets return everything but the pin synchronisers to defaults
  // common reset
  assign soft_rst = reset | bus_soft_reset;

  assign wr_mode_one = reg_wr && (reg_addr == ldmc_pkg::MODE_CONTROL_ONE_ADDR);
  assign wr_mode_two = reg_wr && (reg_addr == ldmc_pkg::MODE_CONTROL_TWO_ADDR);
  assign wr_sel      = reg_wr && is_sel_addr(reg_addr);

  // Pin synchronisers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      oe_meta   <= 1'b1;
      oe_sync_n <= 1'b1;
    end else begin
      oe_meta   <= output_enable_n;
      oe_sync_n <= oe_meta;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      therm_meta <= 1'b0;
      therm_sync <= 1'b0;
    end else begin
      therm_meta <= thermal_alarm;
      therm_sync <= therm_meta;
    end
  end

  // Mode register one; the auto-increment flag is a constant 1 on read
  // range bits
  always_ff @(posedge sys_clk) begin
    if (soft_rst) begin
      mode_one <= ldmc_pkg::MODE_ONE_RESET;
    end else if (wr_mode_one) begin
      mode_one <= reg_wdata;
    end
  end

  assign autoinc_range_hi        = mode_one[ldmc_pkg::AUTOINC_HI_BIT];
  assign autoinc_range_lo        = mode_one[ldmc_pkg::AUTOINC_LO_BIT];
  assign secondary_addr_one_en   = mode_one[ldmc_pkg::SEC_ONE_BIT];
  assign secondary_addr_two_en   = mode_one[ldmc_pkg::SEC_TWO_BIT];
  assign secondary_addr_three_en = mode_one[ldmc_pkg::SEC_THREE_BIT];
  assign broadcast_addr_en       = mode_one[ldmc_pkg::BROADCAST_BIT];
  assign osc_enable              = ~mode_one[ldmc_pkg::SLEEP_BIT];

  // Wake timer: modulation restarts only once the oscillator is counted stable
  // Brightness changes inside this window are the host's to avoid
  // wake window
  always_ff @(posedge sys_clk) begin
    if (soft_rst) begin
      wake_cnt  <= '0;
      osc_ready <= 1'b1;
    end else if (!osc_enable) begin
      wake_cnt  <= '0;
      osc_ready <= 1'b0;
    end else if (!osc_ready) begin
      if (wake_cnt == WAKE_LAST) begin
        osc_ready <= 1'b1;
      end else begin
        wake_cnt <= wake_cnt + 1'b1;
      end
    end
  end

  // Mode register two writable bits; status and reserved bits ignore writes
  // group select
  always_ff @(posedge sys_clk) begin
    if (soft_rst) begin
      group_blink_select   <= 1'b0;
      update_on_ack_select <= 1'b0;
    end else if (wr_mode_two) begin
      group_blink_select   <= reg_wdata[ldmc_pkg::BLINK_SEL_BIT];
      update_on_ack_select <= reg_wdata[ldmc_pkg::UPDATE_ACK_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (soft_rst) begin
      fault_clear_strobe <= 1'b0;
    end else begin
      fault_clear_strobe <= wr_mode_two && reg_wdata[ldmc_pkg::FAULT_CLEAR_BIT];
    end
  end

  // A fault seen in the clear cycle survives: set wins over clear
  // set wins
  always_ff @(posedge sys_clk) begin
    if (soft_rst) begin
      error_summary <= 1'b0;
    end else if (fault_detect) begin
      error_summary <= 1'b1;
    end else if (wr_mode_two && reg_wdata[ldmc_pkg::FAULT_CLEAR_BIT]) begin
      error_summary <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (soft_rst) begin
      thermal_fault_flag <= 1'b0;
    end else begin
      thermal_fault_flag <= therm_sync;
    end
  end

  // Shadow copies take writes at once and read back what was written
  // selector registers
  always_ff @(posedge sys_clk) begin
    if (soft_rst) begin
      for (int i = 0; i < NUM_SEL; i++) begin
        sel_shadow[i] <= ldmc_pkg::SEL_REG_RESET;
      end
    end else if (wr_sel) begin
      sel_shadow[sel_index(reg_addr)] <= reg_wdata;
    end
  end

  // Active copies drive the outputs; in stop mode a multi-byte burst lands together
  // stop or ack update
  always_ff @(posedge sys_clk) begin
    if (soft_rst) begin
      for (int i = 0; i < NUM_SEL; i++) begin
        sel_active[i] <= ldmc_pkg::SEL_REG_RESET;
      end
    end else if (update_on_ack_select && wr_sel) begin
      sel_active[sel_index(reg_addr)] <= reg_wdata;
    end else if (bus_stop) begin
      for (int i = 0; i < NUM_SEL; i++) begin
        sel_active[i] <= sel_shadow[i];
      end
    end
  end

  // Read data, registered
  // reserved read pattern
  always_ff @(posedge sys_clk) begin
    if (soft_rst) begin
      reg_rdata <= '0;
    end else if (reg_addr == ldmc_pkg::MODE_CONTROL_ONE_ADDR) begin
      reg_rdata <= {1'b1, mode_one[6:0]};
    end else if (reg_addr == ldmc_pkg::MODE_CONTROL_TWO_ADDR) begin
      reg_rdata <= {thermal_fault_flag, error_summary, group_blink_select, 1'b0,
                    update_on_ack_select, ldmc_pkg::MODE_TWO_RSVD};
    end else if (is_sel_addr(reg_addr)) begin
      reg_rdata <= sel_shadow[sel_index(reg_addr)];
    end else begin
      reg_rdata <= '0;
    end
  end

  // Step divider: 256 steps per individual period, halted while asleep
  // clock stops
  always_ff @(posedge sys_clk) begin
    if (soft_rst || !osc_ready) begin
      step_div  <= '0;
      step_tick <= 1'b0;
    end else if (step_div == STEP_LAST) begin
      step_div  <= '0;
      step_tick <= 1'b1;
    end else begin
      step_div  <= step_div + 1'b1;
      step_tick <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (soft_rst || !osc_ready) begin
      indiv_cnt <= '0;
    end else if (step_tick) begin
      indiv_cnt <= indiv_cnt + 1'b1;
    end
  end

  assign period_tick = step_tick && (indiv_cnt == CNT_LAST);

  // Group step: every individual period when dimming, slower when blinking
  always_ff @(posedge sys_clk) begin
    if (soft_rst || !osc_ready) begin
      blink_pre <= '0;
      blink_div <= '0;
    end else if (period_tick && group_blink_select) begin
      if (blink_pre == BLINK_PRE_LAST) begin
        blink_pre <= '0;
        blink_div <= (blink_div == group_period_reg) ? 8'h00 : blink_div + 1'b1;
      end else begin
        blink_pre <= blink_pre + 1'b1;
      end
    end
  end

  assign group_step = group_blink_select
                    ? (period_tick && (blink_pre == BLINK_PRE_LAST) && (blink_div == group_period_reg))
                    : period_tick;

  always_ff @(posedge sys_clk) begin
    if (soft_rst || !osc_ready) begin
      group_cnt <= '0;
    end else if (group_step) begin
      group_cnt <= group_cnt + 1'b1;
    end
  end

  // Output mux, all outputs gated by the enable pin
  // Brightness inputs are used live, so a change mid-period shows at once
  always_ff @(posedge sys_clk) begin
    if (soft_rst) begin
      led_drive <= '0;
    end else begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        logic [1:0] sel;
        logic       indiv_on;
        logic       group_on;
        sel      = sel_active[ch / CH_PER_SEL][(ch % CH_PER_SEL) * SEL_W +: SEL_W];
        indiv_on = osc_ready && (indiv_cnt < channel_brightness_reg[ch * 8 +: 8]);
        group_on = osc_ready && (group_cnt < group_duty_reg);
        unique case (sel)
          ldmc_pkg::SEL_OFF:   led_drive[ch] <= 1'b0;
          ldmc_pkg::SEL_ON:    led_drive[ch] <= ~oe_sync_n;
          ldmc_pkg::SEL_INDIV: led_drive[ch] <= ~oe_sync_n & indiv_on;
          ldmc_pkg::SEL_GROUP: led_drive[ch] <= ~oe_sync_n & indiv_on & group_on;
        endcase
      end
    end
  end

endmodule // ldmc_mode_ctrl

// File: shared/ldmc_pkg.sv
package ldmc_pkg;
  localparam int unsigned NUM_CH      = 24;
  localparam int unsigned NUM_SEL_REG = 6;
  localparam int unsigned ADDR_W      = 7;

  // Register offsets
  localparam logic [6:0] MODE_CONTROL_ONE_ADDR   = 7'h00;
  localparam logic [6:0] MODE_CONTROL_TWO_ADDR   = 7'h01;
  localparam logic [6:0] CHANNEL_STATE_BASE_ADDR = 7'h02;
  localparam logic [6:0] CHANNEL_STATE_LAST_ADDR = 7'h07;

  // Mode register one fields
  localparam int unsigned AUTOINC_ACTIVE_BIT = 7;
  localparam int unsigned AUTOINC_HI_BIT     = 6;
  localparam int unsigned AUTOINC_LO_BIT     = 5;
  localparam int unsigned SLEEP_BIT          = 4;
  localparam int unsigned SEC_ONE_BIT        = 3;
  localparam int unsigned SEC_TWO_BIT        = 2;
  localparam int unsigned SEC_THREE_BIT      = 1;
  localparam int unsigned BROADCAST_BIT      = 0;

  // Mode register two fields
  localparam int unsigned THERMAL_BIT      = 7;
  localparam int unsigned ERROR_BIT        = 6;
  localparam int unsigned BLINK_SEL_BIT    = 5;
  localparam int unsigned FAULT_CLEAR_BIT  = 4;
  localparam int unsigned UPDATE_ACK_BIT   = 3;
  localparam logic [2:0]  MODE_TWO_RSVD    = 3'h5;

  // Reset values
  localparam logic [7:0] MODE_ONE_RESET = 8'h89;
  localparam logic [7:0] SEL_REG_RESET  = 8'haa;

  // Channel selector encodings
  localparam logic [1:0] SEL_OFF   = 2'h0;
  localparam logic [1:0] SEL_ON    = 2'h1;
  localparam logic [1:0] SEL_INDIV = 2'h2;
  localparam logic [1:0] SEL_GROUP = 2'h3;

  // Timing
  localparam longint unsigned SYS_CLK_HZ     = 200_000_000;
  localparam longint unsigned INDIV_PWM_HZ   = 31_250;
  localparam longint unsigned PWM_STEPS      = 256;
  localparam longint unsigned STEP_CYCLES    = SYS_CLK_HZ / (INDIV_PWM_HZ * PWM_STEPS);
  localparam longint unsigned WAKE_TIME_US   = 500;
  localparam longint unsigned WAKE_CYCLES    = (WAKE_TIME_US * SYS_CLK_HZ) / 1_000_000;
  // Blink steps run at one eighth of the individual period rate per period unit
  localparam int unsigned     BLINK_PRESCALE = 8;
endpackage : ldmc_pkg

// File: tb/ldmc_host_model.sv
module ldmc_host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [6:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            bus_stop
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr  = 7'h7f;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    bus_stop  = 1'b0;
  end

  // One strobe per acknowledged byte; data scrambled once released
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask

  task automatic stop();
    @(negedge sys_clk);
    bus_stop = 1'b1;
    @(negedge sys_clk);
    bus_stop = 1'b0;
  endtask

  // Read data is registered, so it is taken a cycle after the address
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
endmodule // ldmc_host_model

// File: tb/ldmc_mode_ctrl_props.sv
module ldmc_mode_ctrl_props #(
  parameter int unsigned NUM_CH      = 24,
  parameter int unsigned WAKE_CYCLES = 20
) (
  input wire logic              sys_clk,
  input wire logic              reset,
  input wire logic              bus_soft_reset,
  input wire logic [6:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic [7:0]        reg_rdata,
  input wire logic              autoinc_range_hi,
  input wire logic              autoinc_range_lo,
  input wire logic              secondary_addr_one_en,
  input wire logic              secondary_addr_two_en,
  input wire logic              secondary_addr_three_en,
  input wire logic              broadcast_addr_en,
  input wire logic              osc_enable,
  input wire logic              osc_ready,
  input wire logic              fault_clear_strobe,
  input wire logic [NUM_CH-1:0] led_drive
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WAKE_MAX = WAKE_CYCLES + 2;
  logic       rd_ok;
  logic [6:0] rd_addr;
  wire logic  wr_one = reg_wr && reg_addr == 7'h00 && !bus_soft_reset;
  wire logic  wr_two = reg_wr && reg_addr == 7'h01 && !bus_soft_reset;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // Read data of a cycle that a reset forced to zero must not be judged
  always_ff @(posedge sys_clk) begin
    rd_ok   <= !reset && !bus_soft_reset;
    rd_addr <= reg_addr;
  end

  property p_mode_one_wr; wr_one |=> {autoinc_range_hi, autoinc_range_lo, ~osc_enable, secondary_addr_one_en,
    secondary_addr_two_en, secondary_addr_three_en, broadcast_addr_en} == $past(reg_wdata[6:0]); endproperty
  a_mode_one_wr: assert property (p_mode_one_wr) else $error("mode one bits differ from write");
  property p_sleep; wr_one && reg_wdata[4] |=> !osc_enable ##1 !osc_ready; endproperty
  a_sleep: assert property (p_sleep) else $error("oscillator kept running");
  property p_wake; $rose(osc_enable) && rd_ok |-> !osc_ready [*4] ##[1:WAKE_MAX] osc_ready; endproperty
  a_wake: assert property (p_wake) else $error("wake time wrong");
  property p_clr_pulse; wr_two && reg_wdata[4] |=> fault_clear_strobe ##1 !fault_clear_strobe; endproperty
  a_clr_pulse: assert property (p_clr_pulse) else $error("clear strobe not one cycle");
  property p_clr_cause; fault_clear_strobe |-> $past(wr_two) && $past(reg_wdata[4]); endproperty
  a_clr_cause: assert property (p_clr_cause) else $error("clear strobe without write");
  property p_rd_one; rd_ok && rd_addr == 7'h00 |-> reg_rdata[7]; endproperty
  a_rd_one: assert property (p_rd_one) else $error("auto-increment flag low");
  property p_rd_two; rd_ok && rd_addr == 7'h01 |-> !reg_rdata[4] && reg_rdata[2:0] == 3'h5; endproperty
  a_rd_two: assert property (p_rd_two) else $error("mode two fixed bits wrong");
  property p_rst_vals; !rd_ok |-> osc_enable && osc_ready && broadcast_addr_en && secondary_addr_one_en &&
    !secondary_addr_two_en && !secondary_addr_three_en && !autoinc_range_hi && !autoinc_range_lo &&
    led_drive == '0; endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");

  c_wake: cover property ($rose(osc_ready));
  c_clear: cover property (fault_clear_strobe);
  c_full_on: cover property (led_drive == '1);
endmodule // ldmc_mode_ctrl_props

bind ldmc_mode_ctrl ldmc_mode_ctrl_props #(.NUM_CH(NUM_CH), .WAKE_CYCLES(WAKE_CYCLES)) u_ldmc_mode_ctrl_props (
  .sys_clk, .reset, .bus_soft_reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata, .autoinc_range_hi,
  .autoinc_range_lo, .secondary_addr_one_en, .secondary_addr_two_en, .secondary_addr_three_en,
  .broadcast_addr_en, .osc_enable, .osc_ready, .fault_clear_strobe, .led_drive
);

// File: tb/tb_led_driver_mode_and_output_state_control.sv
module tb_led_driver_mode_and_output_state_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WAKE   = 20;
  localparam int PERIOD = 256 * int'(ldmc_pkg::STEP_CYCLES);
  logic         sys_clk, reset, bus_soft_reset, oe_n, thermal_alarm, fault_detect;
  logic         reg_wr, bus_stop, osc_enable, osc_ready, fault_clear_strobe;
  logic [6:0]   reg_addr;
  logic [7:0]   reg_wdata, reg_rdata, group_duty, group_period;
  logic [5:0]   addr_en;
  logic [23:0]  led_drive;
  logic [191:0] bright;
  int           miscompares, n_tests;

  ldmc_mode_ctrl #(.WAKE_CYCLES(WAKE)) u_ldmc_mode_ctrl (
    .sys_clk(sys_clk), .reset(reset), .bus_soft_reset(bus_soft_reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .bus_stop(bus_stop), .reg_rdata(reg_rdata),
    .output_enable_n(oe_n), .thermal_alarm(thermal_alarm), .fault_detect(fault_detect),
    .channel_brightness_reg(bright), .group_duty_reg(group_duty), .group_period_reg(group_period),
    .autoinc_range_hi(addr_en[5]), .autoinc_range_lo(addr_en[4]), .secondary_addr_one_en(addr_en[3]),
    .secondary_addr_two_en(addr_en[2]), .secondary_addr_three_en(addr_en[1]),
    .broadcast_addr_en(addr_en[0]), .osc_enable(osc_enable), .osc_ready(osc_ready),
    .fault_clear_strobe(fault_clear_strobe), .led_drive(led_drive));

  ldmc_host_model u_ldmc_host_model (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .bus_stop(bus_stop));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_ldmc_host_model.wr(a, d);
  endtask

  task automatic stop();
    u_ldmc_host_model.stop();
    @(negedge sys_clk);
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [7:0] e, input string what);
    logic [7:0] d;
    u_ldmc_host_model.rd(a, d);
    chk(what, 32'(e), 32'(d));
  endtask

  task automatic all_sel(input logic [7:0] d);
    for (int i = 2; i < 8; i++) begin
      wr(7'(i), d);
    end
  endtask

  task automatic t_reset_vals();
    rdchk(7'h00, 8'h89, "mode one reset");
    rdchk(7'h01, 8'h05, "mode two reset");
    for (int i = 2; i < 8; i++) begin
      rdchk(7'(i), 8'haa, "selector reset");
    end
    rdchk(7'h08, 8'h00, "unmapped");
  endtask

  task automatic t_mode_bits();
    wr(7'h00, 8'h6e);
    rdchk(7'h00, 8'hee, "mode one");
    chk("address enables", 32'h3e, 32'(addr_en));
    wr(7'h00, 8'h89);
    wr(7'h01, 8'hff);
    rdchk(7'h01, 8'h2d, "mode two");
    wr(7'h01, 8'h00);
  endtask

  task automatic t_update();
    all_sel(8'h55);
    chk("held until stop", 32'h0, 32'(led_drive));
    stop();
    chk("full on", 32'hffffff, 32'(led_drive));
    oe_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("gated by enable", 32'h0, 32'(led_drive));
    oe_n = 1'b0;
    all_sel(8'h00);
    stop();
    chk("off", 32'h0, 32'(led_drive));
    wr(7'h01, 8'h08);
    wr(7'h07, 8'h55);
    @(negedge sys_clk);
    chk("on at ack", 32'hf00000, 32'(led_drive));
    wr(7'h01, 8'h00);
    all_sel(8'haa);
    stop();
  endtask

  // Second window runs with full group duty and blinking selected
  task automatic t_pwm();
    int c[3];
    bright[23:0] = 24'h40ff40;
    wr(7'h02, 8'h3a);
    stop();
    for (int w = 0; w < 2; w++) begin
      c = '{0, 0, 0};
      repeat (PERIOD) begin
        @(negedge sys_clk);
        for (int i = 0; i < 3; i++) begin
          c[i] += int'(led_drive[i]);
        end
      end
      chk("individual duty", 32'(64 * PERIOD / 256), 32'(c[0]));
      chk("top duty", 32'(255 * PERIOD / 256), 32'(c[1]));
      chk("group and individual", 32'(w * 64 * PERIOD / 256), 32'(c[2]));
      group_duty = 8'hff;
      wr(7'h01, 8'h20);
    end
    group_duty = 8'h00;
    wr(7'h01, 8'h00);
  endtask

  task automatic t_sleep();
    wr(7'h02, 8'h7a);
    stop();
    wr(7'h00, 8'h99);
    repeat (4) @(negedge sys_clk);
    chk("oscillator off", 32'h0, {30'h0, osc_enable, osc_ready});
    chk("no modulation", 32'h8, 32'(led_drive));
    wr(7'h00, 8'h89);
    // Brightness inputs left alone while waking
    repeat (WAKE / 2) @(negedge sys_clk);
    chk("still waking", 32'h0, 32'(osc_ready));
    repeat (WAKE / 2 + 5) @(negedge sys_clk);
    chk("awake", 32'h1, 32'(osc_ready));
  endtask

  task automatic t_fault();
    for (int k = 0; k < 2; k++) begin
      fault_detect = 1'b1;
      @(negedge sys_clk);
      fault_detect = 1'b0;
      rdchk(7'h01, 8'h45, "error set");
      wr(7'h01, 8'h10);
      rdchk(7'h01, 8'h05, "error cleared");
    end
    // Fault held across the clearing write must survive it
    fault_detect = 1'b1;
    wr(7'h01, 8'h10);
    fault_detect = 1'b0;
    rdchk(7'h01, 8'h45, "set beats clear");
    wr(7'h01, 8'h10);
    rdchk(7'h01, 8'h05, "cleared again");
    thermal_alarm = 1'b1;
    repeat (3) @(negedge sys_clk);
    rdchk(7'h01, 8'h85, "overheat");
    thermal_alarm = 1'b0;
  endtask

  task automatic t_soft();
    wr(7'h00, 8'h6e);
    wr(7'h03, 8'h00);
    bus_soft_reset = 1'b1;
    @(negedge sys_clk);
    bus_soft_reset = 1'b0;
    rdchk(7'h00, 8'h89, "soft reset mode");
    rdchk(7'h03, 8'haa, "soft reset selector");
  endtask

  initial begin
    {reset, bus_soft_reset, oe_n, thermal_alarm, fault_detect} = 5'h10;
    bright = '0;
    group_duty = 8'h00;
    group_period = 8'h03;
    miscompares = 0;
    n_tests = 0;
    repeat (6) @(negedge sys_clk);
    reset = 1'b0;
    t_reset_vals();
    t_mode_bits();
    t_update();
    t_pwm();
    t_sleep();
    t_fault();
    t_soft();
    give_verdict();
  end

  // Whole run is some thirteen thousand cycles
  initial begin
    #300us;
    miscompares++;
    give_verdict();
  end
endmodule // tb_led_driver_mode_and_output_state_control
